/* hw/cts_pkg.sv */
package cts_pkg;
   // timing at 100 MHz
   localparam int unsigned CTS_CLK_HZ = 100_000_000;
   localparam int unsigned CTS_LEAD_MS = 100; // capture lead before carrier drop
   localparam int unsigned CTS_DELAY_MS = 500; // tone start after carrier drop
   localparam int unsigned CTS_LEAD_CYC = CTS_CLK_HZ / 1000 * CTS_LEAD_MS;
   localparam int unsigned CTS_DELAY_CYC = CTS_CLK_HZ / 1000 * CTS_DELAY_MS;
   // history sample tick, default 1 ms
   localparam int unsigned CTS_TICK_US = 1000;
   localparam int unsigned CTS_TICK_CYC = CTS_CLK_HZ / 1_000_000 * CTS_TICK_US;
   // code and set widths
   localparam int unsigned CTS_SEL_W = 3;
   localparam logic [2:0] CTS_SEL_RST = 3'h0; // set 1
   // field positions inside the select code
   localparam int unsigned CTS_BIT0_POS = 0;
   localparam int unsigned CTS_BIT1_POS = 1;
   localparam int unsigned CTS_BIT2_POS = 2;

   // tone request toward the tone generator
   typedef struct packed
   {
      logic start; // one-cycle pulse
      logic [2:0] set_code; // set number minus one
   } cts_tone_s;
endpackage

/* hw/cts_history.sv */
`timescale 1ns/100ps
// delay line of tone-select samples, one entry per tick
module cts_history
#(
   parameter int unsigned DEPTH = 100,
   parameter int unsigned W = 3
)
(
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic ce,
   input wire logic tick,
   input wire logic [W-1:0] din,
   output logic [W-1:0] dout
);
   logic [W-1:0] mem_r [DEPTH];

   // shift line; the last entry is the oldest sample
   generate
      for (genvar i = 0; i < DEPTH; i++)
      begin : g_tap
         always_ff @(posedge clk_sys or negedge rst_n)
         begin
            if (!rst_n)
               mem_r[i] <= '0;
            else if (ce && tick)
               mem_r[i] <= (i == 0) ? din : mem_r[(i == 0) ? 0 : i - 1];
         end
      end
   endgenerate

   assign dout = mem_r[DEPTH-1];
endmodule

/* hw/cts_selector.sv */
`timescale 1ns/100ps
// What this block does
// (RL1) three inputs form binary code, set 1..8
// (RL2) inputs never select alone; merge operator
// (RL3) highest numbered set wins at end
// (RL4) capture inputs about 100 ms before end
// (RL5) tone starts half second after end
// (RL6) unconnected inputs read low
// (RL7) keep sample history to look back
module cts_selector
#(
   parameter int unsigned TICK_CYC = cts_pkg::CTS_TICK_CYC,
   parameter int unsigned HIST_DEPTH = cts_pkg::CTS_LEAD_MS * 1000 / cts_pkg::CTS_TICK_US,
   parameter int unsigned DELAY_CYC = cts_pkg::CTS_DELAY_CYC
)
(
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic ce,
   input wire logic tone_select_bit0,
   input wire logic tone_select_bit1,
   input wire logic tone_select_bit2,
   input wire logic carrier_active,
   input wire logic [cts_pkg::CTS_SEL_W-1:0] operator_set,
   output cts_pkg::cts_tone_s tone_out,
   output logic waiting
);
   import cts_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   // state
   typedef enum logic [2:0]
   {
      CTS_IDLE = 3'b001,
      CTS_ACTIVE = 3'b010,
      CTS_WAIT = 3'b100
   } cts_state_e;

   cts_state_e state_r; // carrier tracking
   logic [31:0] tick_cnt_r; // sample tick divider
   logic tick; // one sample per tick period
   logic [31:0] wait_cnt_r; // post-carrier delay
   logic [CTS_SEL_W-1:0] live_code; // current input code
   logic [CTS_SEL_W-1:0] old_code; // code one lead time ago
   logic [CTS_SEL_W-1:0] latched_r; // captured request
   logic [CTS_SEL_W-1:0] merged; // winner of both requests
   logic carrier_fall;
   logic carrier_d_r;

   ////////////////////////////////////////////////////////////////////////
   // input code; pads carry weak pull-downs, so open pins arrive as 0
   always_comb
   begin
      live_code = '0; // see (RL6)
      live_code[CTS_BIT0_POS] = tone_select_bit0; // see (RL1)
      live_code[CTS_BIT1_POS] = tone_select_bit1;
      live_code[CTS_BIT2_POS] = tone_select_bit2; // most significant
   end

   // sample tick
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
         tick_cnt_r <= '0;
      else if (ce)
         tick_cnt_r <= (tick_cnt_r >= TICK_CYC - 1) ? '0 : tick_cnt_r + 32'h1;
   end
   assign tick = (tick_cnt_r == TICK_CYC - 1);

   // end of carrier is only known afterwards, so look back in a delay line
   cts_history #(.DEPTH(HIST_DEPTH), .W(CTS_SEL_W)) u_hist // see (RL7)
   (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .ce(ce),
      .tick(tick),
      .din(live_code),
      .dout(old_code)
   );

   ////////////////////////////////////////////////////////////////////////
   // carrier edge
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
         carrier_d_r <= 1'b0;
      else if (ce)
         carrier_d_r <= carrier_active;
   end
   assign carrier_fall = carrier_d_r && !carrier_active;

   // capture the code from one lead time before the drop
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
         latched_r <= CTS_SEL_RST;
      else if (ce && carrier_fall && state_r == CTS_ACTIVE)
         latched_r <= old_code; // see (RL4)
   end

   // operator choice always joins; larger code is larger set number
   assign merged = (latched_r > operator_set) ? latched_r : operator_set; // see (RL2) (RL3)

   ////////////////////////////////////////////////////////////////////////
   // sequence: active, then wait half a second, then start tone
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state_r <= CTS_IDLE;
         wait_cnt_r <= '0;
      end
      else if (ce)
      begin
         case (state_r)
            CTS_IDLE:
            begin
               if (carrier_active)
                  state_r <= CTS_ACTIVE;
            end
            CTS_ACTIVE:
            begin
               if (carrier_fall)
               begin
                  state_r <= CTS_WAIT;
                  wait_cnt_r <= '0;
               end
            end
            CTS_WAIT:
            begin
               // a new key-up cancels the pending tone
               if (carrier_active)
                  state_r <= CTS_ACTIVE;
               else if (wait_cnt_r >= DELAY_CYC - 1)
                  state_r <= CTS_IDLE; // see (RL5)
               else
                  wait_cnt_r <= wait_cnt_r + 32'h1;
            end
            default:
               state_r <= CTS_IDLE;
         endcase
      end
   end

   // tone start pulse and set, from flops
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
         tone_out <= '0;
      else if (ce)
      begin
         tone_out.start <= (state_r == CTS_WAIT) && !carrier_active
            && (wait_cnt_r >= DELAY_CYC - 1); // see (RL5)
         if (state_r == CTS_WAIT)
            tone_out.set_code <= merged; // see (RL3)
      end
      else
         tone_out.start <= 1'b0;
   end

   assign waiting = (state_r == CTS_WAIT);

   ////////////////////////////////////////////////////////////////////////
   // checks
   property p_start_after_wait;
      @(posedge clk_sys) disable iff (!rst_n)
      $rose(tone_out.start) |-> $past(state_r == CTS_WAIT);
   endproperty
   a_start_after_wait: assert property (p_start_after_wait) // see (RL5)
      else $error("tone start without wait");

   property p_set_is_max;
      @(posedge clk_sys) disable iff (!rst_n)
      tone_out.start |-> tone_out.set_code >= $past(operator_set)
         && tone_out.set_code >= $past(latched_r);
   endproperty
   a_set_is_max: assert property (p_set_is_max) // see (RL3)
      else $error("tone set below a request");

   property p_set_not_hw_only;
      @(posedge clk_sys) disable iff (!rst_n)
      tone_out.start && ($past(operator_set) > $past(latched_r))
         |-> tone_out.set_code == $past(operator_set);
   endproperty
   a_set_not_hw_only: assert property (p_set_not_hw_only) // see (RL2)
      else $error("operator choice ignored");

   property p_capture;
      @(posedge clk_sys) disable iff (!rst_n)
      ce && carrier_fall && state_r == CTS_ACTIVE |=> latched_r == $past(old_code);
   endproperty
   a_capture: assert property (p_capture) // see (RL4) (RL7)
      else $error("capture missed history");

   property p_code_map;
      @(posedge clk_sys) disable iff (!rst_n)
      live_code == {tone_select_bit2, tone_select_bit1, tone_select_bit0};
   endproperty
   a_code_map: assert property (p_code_map) // see (RL1) (RL6)
      else $error("code order wrong");

   property p_wait_no_early;
      @(posedge clk_sys) disable iff (!rst_n)
      ce && carrier_fall && state_r == CTS_ACTIVE |=> !tone_out.start [*2];
   endproperty
   a_wait_no_early: assert property (p_wait_no_early) // see (RL5)
      else $error("tone too early");

   property p_wait_leaves;
      @(posedge clk_sys) disable iff (!rst_n)
      state_r == CTS_WAIT |-> wait_cnt_r < DELAY_CYC;
   endproperty
   a_wait_leaves: assert property (p_wait_leaves) // see (RL5)
      else $error("wait counter overran");

   property p_onehot;
      @(posedge clk_sys) disable iff (!rst_n)
      $onehot(state_r);
   endproperty
   a_onehot: assert property (p_onehot)
      else $error("state not one-hot");

   c_tone: cover property (@(posedge clk_sys) disable iff (!rst_n) tone_out.start);
   c_rekey: cover property (@(posedge clk_sys) disable iff (!rst_n)
      state_r == CTS_WAIT ##1 state_r == CTS_ACTIVE);
   c_hw_wins: cover property (@(posedge clk_sys) disable iff (!rst_n)
      tone_out.start && tone_out.set_code > operator_set);
endmodule

/* verification/cts_site_model.sv */
`timescale 1ns/100ps
// site monitor: drives the tone select pins while the user's signal lasts
module cts_site_model
(
   input wire logic clk_sys,
   input wire logic hold, // info still present
   input wire logic [2:0] code, // requested code, bit 2 msb
   input wire logic [2:0] en, // low = pin left open
   output logic tone_select_bit0,
   output logic tone_select_bit1,
   output logic tone_select_bit2
);
   logic [2:0] junk_r = 3'h0; // moves every cycle once info is gone
   logic [2:0] lvl; // level seen on the pins
   ////////////////////////////////////////////////////////////////
   // stale data must never pass for a match, so it keeps changing
   always_ff @(posedge clk_sys)
   begin
      junk_r <= junk_r + 3'h3;
   end
   // open pins sit at the pull-down level
   always_comb
   begin
      lvl = (hold ? code : junk_r) & en;
      tone_select_bit0 = lvl[0];
      tone_select_bit1 = lvl[1];
      tone_select_bit2 = lvl[2];
   end
endmodule

/* verification/tb_top.sv */
`timescale 1ns/100ps
module tb_top;
   import cts_pkg::*;
   localparam int TK = 4; // short tick
   localparam int HD = 4; // short lookback
   localparam int DL = 20; // short tone delay
   logic clk_sys = 1'b0;
   logic rst_n = 1'b0;
   logic ce = 1'b1; // low only while a wait freeze is asked for
   logic carrier_active = 1'b0;
   logic [2:0] operator_set = 3'h0;
   logic hold = 1'b1;
   logic [2:0] code = 3'h0;
   logic [2:0] en = 3'h7;
   logic b0;
   logic b1;
   logic b2;
   cts_tone_s tone_out;
   logic waiting;
   int failures = 0;
   int n_checks = 0;
   int seed = 32'hd22c3020;
   int r;
   int expq[$]; // expected set codes in order
   ////////////////////////////////////////////////////////////////
   cts_site_model i_cts_site_model (.clk_sys(clk_sys), .hold(hold), .code(code), .en(en),
      .tone_select_bit0(b0), .tone_select_bit1(b1), .tone_select_bit2(b2));
   cts_selector #(.TICK_CYC(TK), .HIST_DEPTH(HD), .DELAY_CYC(DL)) i_cts_selector (
      .clk_sys(clk_sys), .rst_n(rst_n), .ce(ce), .tone_select_bit0(b0),
      .tone_select_bit1(b1), .tone_select_bit2(b2), .carrier_active(carrier_active),
      .operator_set(operator_set), .tone_out(tone_out), .waiting(waiting));
   ////////////////////////////////////////////////////////////////
   task automatic conclude();
      $display("checks %0d failures %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0)
      begin
         $display("Regression OK");
      end
      else
      begin
         $display("Regression broken");
      end
      $finish;
   endtask
   task automatic fail(input string msg);
      failures++;
      $display("Error %0t %s", $time, msg);
   endtask
   // one user transmission; late code changes just before the drop
   // fz: enable held low for that many edges inside the post-carrier wait
   task automatic xfer(input logic [2:0] c, input logic [2:0] late, input logic [2:0] op,
      input logic [2:0] msk, input bit cancel, input int fz);
      int n;
      int w;
      logic [2:0] ex;
      @(negedge clk_sys);
      carrier_active = 1'b1;
      code = c;
      operator_set = op;
      en = msk;
      hold = 1'b1;
      repeat (10 * TK) @(negedge clk_sys);
      code = late; // too late to count
      repeat (2) @(negedge clk_sys);
      carrier_active = 1'b0;
      hold = 1'b0; // info goes away with the signal
      expq.push_back(((c & msk) > op) ? (c & msk) : op);
      if (cancel)
      begin
         repeat (5) @(negedge clk_sys);
         carrier_active = 1'b1;
         code = c;
         hold = 1'b1;
         w = 0;
         repeat (10 * TK) @(posedge clk_sys) #1 w += (tone_out.start === 1'b1);
         n_checks++;
         if (w != 0) fail("tone not cancelled");
         @(negedge clk_sys);
         carrier_active = 1'b0;
         hold = 1'b0;
      end
      n = 0;
      w = 0;
      while (tone_out.start !== 1'b1 && n < 100)
      begin
         @(posedge clk_sys);
         n++;
         #1 w += (waiting === 1'b1);
         // frozen edges must stretch the wait, not shorten or skip it
         @(negedge clk_sys);
         ce = !(n >= 2 && n < 2 + fz);
      end
      ex = expq.pop_front();
      n_checks += 5;
      // a hang is counted and the run moves on to the next transfer
      if (n >= 100)
      begin
         fail("no tone");
         return;
      end
      if (n != DL + 1 + fz) fail("tone start at wrong edge");
      if (w != DL + fz) fail("wait length wrong");
      if (tone_out.set_code !== ex) fail("wrong tone set");
      @(posedge clk_sys);
      #1 if (tone_out.start !== 1'b0) fail("start not one cycle");
      $display("test done set %0d", ex + 1);
   endtask
   ////////////////////////////////////////////////////////////////
   initial
   begin
      forever #5 clk_sys = ~clk_sys;
   end
   // every code, open pins, operator win with cancel, then random mixes
   initial
   begin
      repeat (8) @(negedge clk_sys);
      rst_n = 1'b1;
      for (int i = 0; i < 8; i++) xfer(i[2:0], ~i[2:0], 3'h0, 3'h7, 1'b0, 0);
      xfer(3'h5, 3'h7, 3'h0, 3'h0, 1'b0, 0);
      xfer(3'h2, 3'h0, 3'h6, 3'h7, 1'b1, 3);
      for (int i = 0; i < 12; i++)
      begin
         r = $random(seed);
         xfer(r[2:0], r[5:3], r[8:6], 3'h7, r[9], int'(r[11:10]));
      end
      conclude();
   end
endmodule
